// ### design/sar_ctrl_pkg.sv
`default_nettype none
package sar_ctrl_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned RES_W  = 8;
	localparam int unsigned MODE_W = 3;
	localparam int unsigned DIV_W  = 5;
	localparam int unsigned GAIN_W = 2;
	localparam int unsigned CHAN_W = 3;
	localparam int unsigned PAIR_N = 4;
	localparam int unsigned PER_W  = 6;

	// register byte addresses on the special-function bus
	localparam logic [ADDR_W-1:0] ADDR_PAIR_CFG = 8'hba;
	localparam logic [ADDR_W-1:0] ADDR_CHAN_SEL = 8'hbb;
	localparam logic [ADDR_W-1:0] ADDR_CONV_CFG = 8'hbc;
	localparam logic [ADDR_W-1:0] ADDR_RESULT   = 8'hbe;
	localparam logic [ADDR_W-1:0] ADDR_CTRL     = 8'he8;

	// field positions
	localparam int unsigned CTRL_EN_BIT   = 7;
	localparam int unsigned CTRL_TM_BIT   = 6;
	localparam int unsigned CTRL_FLAG_BIT = 5;
	localparam int unsigned CTRL_BUSY_BIT = 4;
	localparam int unsigned CTRL_MODE_LSB = 1;
	localparam int unsigned CFG_DIV_LSB   = 3;
	localparam int unsigned CFG_GAIN_LSB  = 0;

	// reset values
	localparam logic [PAIR_N-1:0] PAIR_RESET   = 4'h0;
	localparam logic [CHAN_W-1:0] CHAN_RESET   = 3'h0;
	localparam logic [DIV_W-1:0]  DIV_RESET    = 5'h1f;
	localparam logic [GAIN_W-1:0] GAIN_RESET   = 2'h0;
	localparam logic [MODE_W-1:0] MODE_RESET   = 3'h0;
	localparam logic [RES_W-1:0]  RESULT_RESET = 8'h00;
	localparam logic [RES_W-1:0]  TRIAL_FIRST  = 8'h80;

	// start sources; any code with the top bit set is the companion start
	localparam logic [MODE_W-1:0] MODE_SW  = 3'h0;
	localparam logic [MODE_W-1:0] MODE_T3  = 3'h1;
	localparam logic [MODE_W-1:0] MODE_EXT = 3'h2;
	localparam logic [MODE_W-1:0] MODE_T2  = 3'h3;

	// timing
	localparam longint unsigned SYS_CLK_HZ = 25_000_000;
	localparam longint unsigned SAR_MAX_HZ = 6_000_000;
	localparam logic [PER_W-1:0] SAR_MIN_PERIOD =
		PER_W'((SYS_CLK_HZ + SAR_MAX_HZ - 1) / SAR_MAX_HZ);
	localparam logic [1:0] LP_TRACK_TICKS = 2'h3;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_TRACK = 2'b01,
		ST_CONV  = 2'b10
	} conv_state_t;
endpackage
`default_nettype wire

// ### design/sar_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface sar_link_if;
	logic       tick;
	logic       start;
	logic       cmp;
	logic       busy;
	logic       done;
	logic [7:0] trial;
	logic [7:0] result;
	modport ctrl   (output tick, output start, output cmp,
			input busy, input done, input trial, input result);
	modport engine (input tick, input start, input cmp,
			output busy, output done, output trial, output result);
endinterface
`default_nettype wire

// ### design/sar_engine.sv
`timescale 1ns/1ps
`default_nettype none
module sar_engine (
	input  wire logic   ref_clk_i,
	input  wire logic   rst_n_i,
	sar_link_if.engine  link
);
	import sar_ctrl_pkg::*;

	logic [2:0]       bit_q;
	logic [RES_W-1:0] trial_q;
	logic [RES_W-1:0] result_q;
	logic             busy_q;
	logic             done_q;

	// one decision per sar tick, msb first
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_q    <= 3'h7;
			trial_q  <= RESULT_RESET;
			result_q <= RESULT_RESET;
			busy_q   <= 1'b0;
			done_q   <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (link.start && !busy_q) begin
				busy_q  <= 1'b1;
				trial_q <= TRIAL_FIRST;
				bit_q   <= 3'h7;
			end else if (busy_q && link.tick) begin
				trial_q[bit_q] <= link.cmp;
				if (bit_q == 3'h0) begin
					busy_q   <= 1'b0;
					done_q   <= 1'b1;
					result_q <= {trial_q[7:1], link.cmp};
				end else begin
					trial_q[3'(bit_q - 3'h1)] <= 1'b1;
					bit_q <= 3'(bit_q - 3'h1);
				end
			end
		end
	end

	assign link.busy   = busy_q;
	assign link.done   = done_q;
	assign link.trial  = trial_q;
	assign link.result = result_q;

	chk_engine_start: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		link.start && !busy_q |=> busy_q && trial_q == TRIAL_FIRST)
		else $error("engine did not start");
	chk_done_ends_busy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
		done_q |-> !busy_q ##1 !done_q)
		else $error("done pulse malformed");
endmodule
`default_nettype wire

// ### design/sar_mux_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module sar_mux_ctrl (
	input  wire logic                             ref_clk_i,
	input  wire logic                             rst_n_i,
	input  wire logic [sar_ctrl_pkg::ADDR_W-1:0]  sfr_addr_i,
	input  wire logic                             sfr_wr_i,
	input  wire logic                             sfr_rd_i,
	input  wire logic [sar_ctrl_pkg::DATA_W-1:0]  sfr_wdata_i,
	output logic      [sar_ctrl_pkg::DATA_W-1:0]  sfr_rdata_o,
	input  wire logic                             timer3_ovf_i,
	input  wire logic                             timer2_ovf_i,
	input  wire logic                             external_convert_start_i,
	input  wire logic                             companion_busy_wr_i,
	input  wire logic                             chip_standby_i,
	input  wire logic                             irq_enable_i,
	input  wire logic                             comparator_i,
	output logic      [sar_ctrl_pkg::RES_W-1:0]   dac_code_o,
	output logic      [sar_ctrl_pkg::CHAN_W-1:0]  mux_pos_o,
	output logic      [sar_ctrl_pkg::CHAN_W-1:0]  mux_neg_o,
	output logic                                  mux_diff_o,
	output logic      [sar_ctrl_pkg::GAIN_W-1:0]  gain_field_o,
	output logic                                  track_o,
	output logic                                  convert_o,
	output logic                                  enable_o,
	output logic                                  conv_irq_o
);
	import sar_ctrl_pkg::*;

	logic [1:0]        rst_sync_q;
	logic              sys_rst_n;
	logic [1:0]        ext_sync_q;
	logic              ext_last_q;
	logic [1:0]        cmp_sync_q;
	logic [PAIR_N-1:0] pair_q;
	logic [CHAN_W-1:0] chan_q;
	logic [DIV_W-1:0]  div_q;
	logic [GAIN_W-1:0] gain_q;
	logic              en_q;
	logic              tm_q;
	logic              flag_q;
	logic [MODE_W-1:0] mode_q;
	logic [RES_W-1:0]  result_q;
	logic [DATA_W-1:0] rdata_q;
	conv_state_t       state_q;
	logic [PER_W-1:0]  div_cnt_q;
	logic [1:0]        trk_q;
	logic [PER_W-1:0]  period;
	logic              tick;
	logic              ctrl_wr;
	logic              sw_start;
	logic              ext_rise;
	logic              trig;
	logic              start_ev;
	logic              direct;
	logic              busy;
	logic              diff_sel;
	logic              trk_done;

	sar_link_if link ();

	sar_engine u_engine (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (sys_rst_n),
		.link      (link.engine)
	);

	// reset asserts at once, releases two edges later
	always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_sync_q <= 2'h0;
		end else begin
			rst_sync_q <= {rst_sync_q[0], 1'b1};
		end
	end
	assign sys_rst_n = rst_sync_q[1];

	// pin and comparator come from outside the clock domain
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			ext_sync_q <= 2'h3;
			ext_last_q <= 1'b1;
			cmp_sync_q <= 2'h0;
		end else begin
			ext_sync_q <= {ext_sync_q[0], external_convert_start_i};
			ext_last_q <= ext_sync_q[1];
			cmp_sync_q <= {cmp_sync_q[0], comparator_i};
		end
	end
	assign ext_rise = ext_sync_q[1] && !ext_last_q;
	assign link.cmp = cmp_sync_q[1];

	assign ctrl_wr = sfr_wr_i && (sfr_addr_i == ADDR_CTRL);

	// configuration registers
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			pair_q <= PAIR_RESET;
			chan_q <= CHAN_RESET;
			div_q  <= DIV_RESET;
			gain_q <= GAIN_RESET;
		end else if (sfr_wr_i) begin
			case (sfr_addr_i)
				ADDR_PAIR_CFG: pair_q <= sfr_wdata_i[PAIR_N-1:0];
				ADDR_CHAN_SEL: chan_q <= sfr_wdata_i[CHAN_W-1:0];
				ADDR_CONV_CFG: begin
					div_q  <= sfr_wdata_i[CFG_DIV_LSB +: DIV_W];
					gain_q <= sfr_wdata_i[CFG_GAIN_LSB +: GAIN_W];
				end
				default: ;
			endcase
		end
	end

	// control register fields other than busy and flag
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			en_q   <= 1'b0;
			tm_q   <= 1'b0;
			mode_q <= MODE_RESET;
		end else if (ctrl_wr) begin
			en_q   <= sfr_wdata_i[CTRL_EN_BIT];
			tm_q   <= sfr_wdata_i[CTRL_TM_BIT];
			mode_q <= sfr_wdata_i[CTRL_MODE_LSB +: MODE_W];
		end
	end

	// completion flag: set beats a same-cycle software clear
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			flag_q <= 1'b0;
		end else if (link.done) begin
			flag_q <= 1'b1;
		end else if (ctrl_wr) begin
			flag_q <= sfr_wdata_i[CTRL_FLAG_BIT];
		end
	end
	assign conv_irq_o = flag_q && irq_enable_i;

	// start source selection
	assign sw_start = ctrl_wr && sfr_wdata_i[CTRL_BUSY_BIT]
		&& (sfr_wdata_i[CTRL_MODE_LSB +: MODE_W] == MODE_SW);
	always_comb begin
		trig = sw_start;
		case (mode_q)
			MODE_SW:  trig = sw_start;
			MODE_T3:  trig = timer3_ovf_i;
			MODE_EXT: trig = ext_rise;
			MODE_T2:  trig = timer2_ovf_i;
			default:  trig = companion_busy_wr_i;
		endcase
	end
	// starts while busy are dropped; the block is not queued
	// a busy write that also picks mode 000 starts at once, whatever mode stood before
	assign start_ev = en_q && (trig || sw_start) && (state_q == ST_IDLE);
	assign direct = !tm_q || (mode_q == MODE_EXT);
	assign busy = (state_q != ST_IDLE);

	// sar clock: divider floored so the sar clock never passes its maximum
	assign period = (PER_W'(div_q) + PER_W'(1) < SAR_MIN_PERIOD) ? SAR_MIN_PERIOD
		: PER_W'(div_q) + PER_W'(1);
	assign tick = busy && (div_cnt_q == PER_W'(period - PER_W'(1)));
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			div_cnt_q <= '0;
		end else if (!busy || tick) begin
			div_cnt_q <= '0; // restart keeps comparator settle time full
		end else begin
			div_cnt_q <= PER_W'(div_cnt_q + PER_W'(1));
		end
	end
	assign link.tick = tick;

	assign trk_done = (state_q == ST_TRACK) && tick
		&& (trk_q == 2'(LP_TRACK_TICKS - 2'h1));
	assign link.start = (start_ev && direct) || trk_done;

	// sequencing: idle, low-power track window, conversion
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			state_q <= ST_IDLE;
			trk_q   <= 2'h0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					trk_q <= 2'h0;
					if (start_ev) begin
						state_q <= direct ? ST_CONV : ST_TRACK;
					end
				end
				ST_TRACK: begin
					if (trk_done) begin
						state_q <= ST_CONV;
					end else if (tick) begin
						trk_q <= 2'(trk_q + 2'h1);
					end
				end
				ST_CONV: begin
					if (link.done) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// even address of a differential pair selects the pair
	assign diff_sel = pair_q[chan_q[2:1]] && !chan_q[0];
	assign mux_pos_o = chan_q;
	assign mux_neg_o = diff_sel ? {chan_q[2:1], 1'b1} : chan_q;
	assign mux_diff_o = diff_sel;
	assign gain_field_o = gain_q;
	assign dac_code_o = link.trial;
	assign convert_o = (state_q == ST_CONV);
	assign enable_o = en_q;

	// standby stops tracking regardless of mode
	always_comb begin
		track_o = 1'b0;
		if (en_q && !chip_standby_i) begin
			if (!tm_q) begin
				track_o = !busy;
			end else begin
				track_o = (state_q == ST_TRACK)
					|| ((mode_q == MODE_EXT) && !busy && !ext_sync_q[1]);
			end
		end
	end

	// result: offset-binary sar code turned to two's complement when differential
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			result_q <= RESULT_RESET;
		end else if (link.done) begin
			result_q <= diff_sel ? {!link.result[7], link.result[6:0]}
				: link.result;
		end
	end

	// read data registered; unmapped addresses read zero
	always_ff @(posedge ref_clk_i or negedge sys_rst_n) begin
		if (!sys_rst_n) begin
			rdata_q <= 8'h00;
		end else if (sfr_rd_i) begin
			case (sfr_addr_i)
				ADDR_PAIR_CFG: rdata_q <= {4'h0, pair_q};
				ADDR_CHAN_SEL: rdata_q <= {5'h00, chan_q};
				ADDR_CONV_CFG: rdata_q <= {div_q, 1'b0, gain_q};
				ADDR_CTRL:     rdata_q <= {en_q, tm_q, flag_q, busy, mode_q, 1'b0};
				ADDR_RESULT:   rdata_q <= result_q;
				default:       rdata_q <= 8'h00;
			endcase
		end
	end
	assign sfr_rdata_o = rdata_q;

	default clocking dc @(posedge ref_clk_i);
	endclocking
	default disable iff (!sys_rst_n);

	chk_flag_on_fall: assert property ($fell(busy) |-> flag_q)
		else $error("flag not set when busy fell");
	chk_sar_period: assert property (tick |=> !tick [*4])
		else $error("sar clock faster than allowed");
	chk_sw_start: assert property (en_q && sw_start && !busy |=> busy)
		else $error("software start ignored");
	chk_timer_start: assert property (en_q && !busy && !tm_q && mode_q == MODE_T3
		&& timer3_ovf_i |=> state_q == ST_CONV)
		else $error("timer 3 start missed");
	chk_ext_start: assert property (en_q && !busy && mode_q == MODE_EXT
		&& ext_rise |=> state_q == ST_CONV)
		else $error("pin edge start missed");
	chk_companion: assert property (en_q && !busy && mode_q[2]
		&& companion_busy_wr_i |=> busy)
		else $error("companion start missed");
	chk_track_window: assert property (state_q == ST_CONV && $past(state_q) == ST_TRACK
		|-> $past(trk_q) == 2'h2 && $past(tick))
		else $error("low-power track window wrong length");
	chk_diff_result: assert property (link.done && diff_sel
		|=> result_q[7] == !$past(link.result[7]))
		else $error("differential result not signed");
	chk_flag_sticky: assert property (flag_q && !ctrl_wr |=> flag_q)
		else $error("flag cleared by hardware");
	chk_normal_track: assert property (!tm_q && busy |-> !track_o)
		else $error("tracking during conversion");
	chk_busy_no_start: assert property (state_q == ST_CONV |-> !link.start)
		else $error("start accepted while busy");
	chk_pair_upper: assert property (sfr_rd_i && sfr_addr_i == ADDR_PAIR_CFG
		|=> sfr_rdata_o[7:4] == 4'h0)
		else $error("pair config upper bits not zero");

	cov_sw_conv: cover property (sw_start ##[1:400] link.done);
	cov_lp_track: cover property (state_q == ST_TRACK ##[1:200] state_q == ST_CONV);
	cov_diff_done: cover property (link.done && diff_sel);
	cov_ext_start: cover property (ext_rise && mode_q == MODE_EXT && start_ev);
endmodule
`default_nettype wire

// ### verification/analog_front_model.sv
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
	input  wire logic [63:0] levels_i,
	input  wire logic [7:0]  dac_code_i,
	input  wire logic [2:0]  mux_pos_i,
	input  wire logic [2:0]  mux_neg_i,
	input  wire logic        mux_diff_i,
	output logic             comparator_o
);
	int lvl;

	// differential level offset by half scale, clipped to the 8-bit span
	always_comb begin
		// every converter pin is taken as analog; no digital path on them
		lvl = int'(levels_i[mux_pos_i*8 +: 8]);
		if (mux_diff_i) begin
			lvl = lvl - int'(levels_i[mux_neg_i*8 +: 8]) + 128;
			if (lvl < 0) lvl = 0;
			if (lvl > 255) lvl = 255;
		end
		comparator_o = (lvl >= int'(dac_code_i));
	end
endmodule
`default_nettype wire

// ### verification/sar_mux_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sar_mux_ctrl_bench;
	import sar_ctrl_pkg::*;
	logic              ref_clk_i;
	logic              rst_n_i;
	logic [ADDR_W-1:0] sfr_addr_i;
	logic              sfr_wr_i;
	logic              sfr_rd_i;
	logic [DATA_W-1:0] sfr_wdata_i;
	logic [DATA_W-1:0] sfr_rdata_o;
	logic              timer3_ovf_i;
	logic              timer2_ovf_i;
	logic              external_convert_start_i;
	logic              companion_busy_wr_i;
	logic              chip_standby_i;
	logic              irq_enable_i;
	logic              comparator_i;
	logic [RES_W-1:0]  dac_code_o;
	logic [CHAN_W-1:0] mux_pos_o;
	logic [CHAN_W-1:0] mux_neg_o;
	logic              mux_diff_o;
	logic [GAIN_W-1:0] gain_field_o;
	logic              track_o;
	logic              convert_o;
	logic              enable_o;
	logic              conv_irq_o;
	logic [63:0]       levels;
	logic [3:0]        pc;
	logic [7:0]        rv;
	logic [7:0]        ra [6] = '{8'hba, 8'hbb, 8'hbc, 8'he8, 8'hbe, 8'h10};
	logic [7:0]        rx [6] = '{8'h00, 8'h00, 8'hf8, 8'h00, 8'h00, 8'h00};
	logic [7:0]        wx [6] = '{8'h0f, 8'h07, 8'hfb, 8'h00, 8'h00, 8'h00};
	logic [7:0]        md [5] = '{8'h01, 8'h03, 8'h02, 8'h04, 8'h07};
	int                tg [5] = '{0, 1, 2, 3, 3};
	int                lv [8];
	int                fail_count = 0;
	int                n_compared = 0;
	int                cyc = 0;
	int                seed;
	int                per;
	int                div;
	int                ch;

	analog_front_model u_afe (
		.levels_i     (levels),
		.dac_code_i   (dac_code_o),
		.mux_pos_i    (mux_pos_o),
		.mux_neg_i    (mux_neg_o),
		.mux_diff_i   (mux_diff_o),
		.comparator_o (comparator_i)
	);

	sar_mux_ctrl u_dut (
		.ref_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i,
		.sfr_rdata_o, .timer3_ovf_i, .timer2_ovf_i, .external_convert_start_i,
		.companion_busy_wr_i, .chip_standby_i, .irq_enable_i, .comparator_i,
		.dac_code_o, .mux_pos_o, .mux_neg_o, .mux_diff_o, .gain_field_o,
		.track_o, .convert_o, .enable_o, .conv_irq_o
	);

	initial begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end

	// hang guard well above the fewer than two thousand cycles the run needs
	always @(posedge ref_clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			fail_count++;
			results();
		end
	end

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %0t seen %h exp %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= a;
		sfr_wdata_i <= d;
		sfr_wr_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_wr_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk_i);
		sfr_addr_i <= a;
		sfr_rd_i <= 1'b1;
		@(posedge ref_clk_i);
		sfr_rd_i <= 1'b0;
		#1 d = sfr_rdata_o;
	endtask

	task automatic trig(input int i, input logic v);
		case (i)
			0: timer3_ovf_i <= v;
			1: timer2_ovf_i <= v;
			2: external_convert_start_i <= v;
			default: companion_busy_wr_i <= v;
		endcase
	endtask

	task automatic pulse(input int i);
		@(posedge ref_clk_i);
		trig(i, 1'b1);
		@(posedge ref_clk_i);
		trig(i, 1'b0);
	endtask

	// poke fires a second start in mid conversion, which must be dropped
	task automatic run(input int trk, input int poke);
		int t;
		int n;
		t = 0;
		#1;
		for (n = 0; n < 2000 && convert_o !== 1'b1; n++) begin
			if (track_o === 1'b1) t++;
			@(posedge ref_clk_i);
			#1;
		end
		if (trk >= 0) chk(t, trk);
		chk(dac_code_o, TRIAL_FIRST);
		t = 0;
		for (n = 0; n < 3000 && convert_o === 1'b1; n++) begin
			if (track_o === 1'b1) t++;
			@(posedge ref_clk_i);
			if (n == 10 && poke >= 0) trig(poke, 1'b1);
			if (n == 11 && poke >= 0) trig(poke, 1'b0);
			#1;
		end
		chk(t, 0);
		// eight decisions, then one cycle for the done pulse to drop busy
		chk(n, 8 * per + 1);
	endtask

	function automatic int exp_res(input int c);
		int d;
		d = lv[c];
		if (pc[c/2] && c % 2 == 0) begin
			d = lv[c] - lv[c+1];
			if (d < -128) d = -128;
			if (d > 127) d = 127;
			d = d & 255;
		end
		return d;
	endfunction

	task automatic finish_conv(input logic [7:0] ctl, input int c);
		rd(ADDR_CTRL, rv);
		chk(rv, ctl | 8'h20);
		chk(conv_irq_o, irq_enable_i);
		rd(ADDR_RESULT, rv);
		chk(rv, exp_res(c));
		chk(convert_o, 1'b0);
		chk(enable_o, ctl[7]);
		wr(ADDR_CTRL, ctl);
		#1 chk(conv_irq_o, 1'b0);
	endtask

	initial begin
		seed = 58795;
		{sfr_addr_i, sfr_wdata_i, sfr_wr_i, sfr_rd_i} = '0;
		{timer3_ovf_i, timer2_ovf_i, external_convert_start_i, companion_busy_wr_i} = '0;
		{chip_standby_i, irq_enable_i} = '0;
		rst_n_i = 1'b0;
		levels = '0;
		pc = '0;
		per = 5;
		repeat (20) @(posedge ref_clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge ref_clk_i);
		chk(gain_field_o, 2'h0);
		foreach (ra[i]) begin
			rd(ra[i], rv);
			chk(rv, rx[i]);
		end
		// all ones written everywhere but the control register; unused bits and read-only places hold
		foreach (ra[i]) begin
			if (i != 3) wr(ra[i], 8'hff);
			rd(ra[i], rv);
			chk(rv, wx[i]);
		end
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_CONV_CFG, 8'h20 | 8'(g));
			#1 chk(gain_field_o, g);
		end
		wr(ADDR_CTRL, 8'h80);
		#1 chk(track_o, 1'b1);
		@(posedge ref_clk_i);
		chip_standby_i <= 1'b1;
		@(posedge ref_clk_i);
		#1 chk(track_o, 1'b0);
		@(posedge ref_clk_i);
		chip_standby_i <= 1'b0;
		for (ch = 0; ch < 8; ch++) begin
			foreach (lv[i]) begin
				lv[i] = $random(seed) & 255;
				levels[i*8 +: 8] = 8'(lv[i]);
			end
			pc = 4'($random(seed));
			div = (ch % 3 == 0) ? 9 : ((ch % 3 == 1) ? 4 : 1);
			per = (div + 1 > 5) ? div + 1 : 5;
			@(posedge ref_clk_i);
			irq_enable_i <= 1'($random(seed));
			wr(ADDR_PAIR_CFG, {4'h0, pc});
			wr(ADDR_CHAN_SEL, 8'(ch));
			wr(ADDR_CONV_CFG, {div[4:0], 3'h0});
			#1 chk(mux_pos_o, ch);
			chk(mux_diff_o, pc[ch/2] && ch % 2 == 0);
			if (pc[ch/2] && ch % 2 == 0) chk(mux_neg_o, ch + 1);
			repeat (20) @(posedge ref_clk_i);
			wr(ADDR_CTRL, (ch >= 6) ? 8'hc0 : 8'h80);
			wr(ADDR_CTRL, (ch >= 6) ? 8'hd0 : 8'h90);
			run((ch >= 6) ? 3 * per : 0, -1);
			finish_conv((ch >= 6) ? 8'hc0 : 8'h80, ch);
		end
		ch = 7;
		foreach (md[k]) begin
			wr(ADDR_CTRL, 8'h80 | (md[k] << 1));
			pulse((tg[k] + 1) % 4);
			wr(ADDR_CTRL, 8'h90 | (md[k] << 1));
			repeat (6) @(posedge ref_clk_i);
			#1 chk(convert_o, 1'b0);
			pulse(tg[k]);
			run(-1, tg[k]);
			finish_conv(8'h80 | (md[k] << 1), ch);
		end
		// busy write that also switches back from companion mode to software start
		wr(ADDR_CTRL, 8'h90);
		run(0, -1);
		finish_conv(8'h80, ch);
		wr(ADDR_CTRL, 8'hc2);
		pulse(0);
		run(3 * per, -1);
		finish_conv(8'hc2, ch);
		wr(ADDR_CTRL, 8'hc4);
		repeat (4) @(posedge ref_clk_i);
		#1 chk(track_o, 1'b1);
		pulse(2);
		run(-1, -1);
		finish_conv(8'hc4, ch);
		results();
	end
endmodule
`default_nettype wire
